// ===== srm_pkg.sv
// Constants and types shared by the reset source manager
package srm_pkg;
    // Timing
    localparam int CLK_PERIOD_NS  = 4;
    localparam int PIN_FILTER_NS  = 36000;
    localparam int PIN_FILTER_CYC =
        (PIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRETCH_CYC    = 16;

    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_CAUSE    = 8'h00;
    localparam logic [7:0] OFS_BLKRST   = 8'h04;
    localparam logic [7:0] OFS_AIRC     = 8'h08;
    localparam logic [7:0] OFS_IMASK    = 8'h0c;
    localparam logic [7:0] OFS_WDCTL    = 8'h10;
    localparam logic [7:0] OFS_WDALT    = 8'h14;
    localparam logic [7:0] OFS_WWCTL    = 8'h18;
    localparam logic [7:0] OFS_WWCNT    = 8'h1c;
    localparam logic [7:0] OFS_WWRLD    = 8'h20;
    localparam logic [7:0] OFS_WWSTS    = 8'h24;
    localparam logic [7:0] OFS_BOOT     = 8'h28;
    localparam logic [7:0] OFS_DFBASE   = 8'h2c;
    localparam logic [7:0] OFS_BODCTL   = 8'h30;
    localparam logic [7:0] OFS_CLKCTL   = 8'h34;
    localparam logic [7:0] OFS_CLKSTS   = 8'h38;

    // Field positions
    localparam int BLK_CHIP_BIT   = 0;
    localparam int BLK_CORE_BIT   = 1;
    localparam int AIRC_MCU_BIT   = 2;
    localparam int WD_RSTEN_BIT   = 1;
    localparam int WD_EN_BIT      = 7;
    localparam int BOOT_BS_BIT    = 1;
    localparam int BOOT_BL_BIT    = 16;
    localparam int BOOT_CBS_LSB   = 2;
    localparam int BOD_EN_BIT     = 0;
    localparam int BOD_LVL_LSB    = 1;
    localparam int BOD_RST_BIT    = 3;
    localparam int CLK_WSEL_LSB   = 0;
    localparam int CLK_WGATE_BIT  = 4;
    localparam int CLK_LXT_BIT    = 8;
    localparam int STS_OSC_BIT    = 0;
    localparam int STS_PLL_BIT    = 2;
    localparam int STS_FAIL_BIT   = 7;
    localparam int CF0_WDEN_BIT   = 31;
    localparam int CF0_RSTEN_BIT  = 30;
    localparam int CF0_BROWNOUT_ENABLE_BIT  = 23;
    localparam int CF0_BROWNOUT_LEVEL_LSB  = 21;
    localparam int CF0_BODRST_BIT = 20;
    localparam int CF0_CBS_LSB    = 6;
    localparam int CF0_BL_BIT     = 1;

    // Reset values
    localparam logic [31:0] CAUSE_POR_VAL = 32'h0000_0001;
    localparam logic [31:0] CAUSE_MASK    = 32'h0000_01bf;
    localparam logic [31:0] WDCTL_RST     = 32'h0000_0700;
    localparam logic [31:0] WWCTL_RST     = 32'h003f_0800;
    localparam logic [5:0]  WWCNT_RST     = 6'h3f;
    localparam logic [1:0]  WSEL_RST      = 2'h3;

    // Reset sources, one bit each in an event vector
    typedef enum int {
        SRC_POR, SRC_PIN, SRC_WDT, SRC_LV, SRC_BO,
        SRC_LOCK, SRC_CHIP, SRC_MCU, SRC_CORE
    } srm_src_type;
    localparam int NSRC = 9;
    localparam int SRC_CAUSE [NSRC] = '{0, 1, 2, 3, 4, 8, 0, 5, 7};
    localparam logic [8:0] GRP_FULL  = 9'h05f;
    localparam logic [8:0] GRP_BOD   = 9'h0ef;
    localparam logic [8:0] GRP_WSEL  = 9'h003;
    localparam logic [8:0] GRP_WGATE = 9'h045;
    localparam logic [8:0] GRP_POR   = 9'h001;
    localparam logic [8:0] GRP_PERI  = 9'h0ff;
    localparam logic [8:0] GRP_CORE  = 9'h100;

    typedef struct packed {
        logic [31:0] wdogCtrl;
        logic [31:0] wdogAltCtrl;
        logic [31:0] wwdogCtrl;
        logic [5:0]  wwdogCount;
        logic [31:0] wwdogReload;
        logic [31:0] wwdogFlags;
        logic        bootSelect;
        logic        bootLock;
        logic [1:0]  cfgBootSource;
        logic [31:0] dataFlashBase;
        logic        bodEnable;
        logic [1:0]  bodLevel;
        logic        bodResetEnable;
        logic [1:0]  wdogClockSelect;
        logic        wdogClockGate;
        logic        lowSpeedXtalEnable;
        logic        clockFailFlag;
        logic        oscStableFlag;
        logic        pllStableFlag;
    } srm_fields_type;
endpackage : srm_pkg

// ===== srm_sync.sv
// Two-stage synchroniser, one chain per bit
`timescale 1ns/1ns
`default_nettype none
module srm_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,   // System clock
    input  wire logic         rst,   // Async reset, high
    input  wire logic [W-1:0] din,   // Asynchronous levels
    output var  logic [W-1:0] dout   // Synchronised levels
);
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic meta;
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                meta    <= 1'b0;
                dout[i] <= 1'b0;
            end else begin
                meta    <= din[i];
                dout[i] <= meta;
            end
        end
    end
endmodule : srm_sync
`default_nettype wire

// ===== srm_pin_filter.sv
// Glitch filter for the external reset pin
`timescale 1ns/1ns
`default_nettype none
module srm_pin_filter #(
    parameter int CYC = 9000
) (
    input  wire logic clk,       // System clock
    input  wire logic rst,       // Async reset, high
    input  wire logic pinLow,    // Synchronised pin is low
    output var  logic asserted   // Filtered reset request
);
    logic [13:0] cnt_reg;
    logic [13:0] cnt_next;
    logic        asserted_next;

    // Level must differ for more than CYC cycles before it flips
    always_comb begin
        cnt_next      = 14'h0;
        asserted_next = asserted;
        if (pinLow != asserted) begin
            if (cnt_reg == 14'(CYC)) begin
                asserted_next = pinLow;
            end else begin
                cnt_next = cnt_reg + 14'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg  <= 14'h0;
            asserted <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            asserted <= asserted_next;
        end
    end

    AST_PIN_LEN: assert property (@(posedge clk) disable iff (rst)
        $changed(asserted) |-> $past(cnt_reg) == 14'(CYC))
        else $error("pin level accepted before filter time");
endmodule : srm_pin_filter
`default_nettype wire

// ===== srm_reset_manager.sv
// Reset source manager: cause flags, reset outputs, field reloads
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Nine sources: power-on, pin, watchdog, low volt, brown-out, lockup, 3 soft.
// - Writing 1 to block reset bit 0 resets core and all peripherals.
// - Writing 1 to the MCU request bit reboots, boot choice kept.
// - Writing 1 to block reset bit 1 resets the core only.
// - All sources except core-only reset both core and peripherals.
// - One sticky cause flag per source, chip reset sharing the power-on flag, readable by software.
// - Fields unaffected by a source keep their previous value.
// - Full resets set watchdog control 0x0700, bits 1 and 7 from config.
// - Full resets set window watchdog registers to their reset values.
// - Full resets reload boot select, lock and boot source from user_config_word0.
// - Full resets reload data flash base from config word 1.
// - Brown-out fields reload on all sources but brown-out and core.
// - Clock select 3 on power-on/pin; clock gate 1 on por/wdog/chip.
// - Clock fail cleared by por/pin; stable flags, crystal by por.
// - Software clears a cause flag by writing 1 to it.
// - Pin reset taken and released after 36 us steady level.
module srm_reset_manager
    import srm_pkg::*;
#(
    parameter int PIN_FILTER_CYCLES = srm_pkg::PIN_FILTER_CYC
) (
    input  wire logic                  clk,          // System clock
    input  wire logic                  rst,          // Power-on reset
    input  wire logic [7:0]            regAddr,      // Register address
    input  wire logic [31:0]           regWdata,     // Write data
    input  wire logic                  regWr,        // Write strobe
    input  wire logic                  regRd,        // Read strobe
    output var  logic [31:0]           regRdata,     // Read data
    input  wire logic                  extResetPin_n,// Reset pin
    input  wire logic                  wdogTimeout,  // Watchdog timeout
    input  wire logic                  lowVoltage,   // Low-voltage level
    input  wire logic                  brownout,     // Brown-out level
    input  wire logic                  lockup,       // Core lockup
    input  wire logic                  debugMode,    // Debug active
    input  wire logic                  clockFail,    // Clock fail event
    input  wire logic                  oscStable,    // Oscillator stable
    input  wire logic                  pllStable,    // PLL stable
    input  wire logic [31:0]           userCfg0,     // Config word 0
    input  wire logic [31:0]           userCfg1,     // Config word 1
    output var  logic                  coreReset,    // Core reset out
    output var  logic                  periphReset,  // Peripheral reset
    output var  logic                  irq,          // Interrupt level
    output var  srm_pkg::srm_fields_type fields      // Retained fields
);
    import srm_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_HOLD = 2'b10
    } srm_state_type;

    localparam int SY_PIN  = 0;
    localparam int SY_WDT  = 1;
    localparam int SY_LV   = 2;
    localparam int SY_BO   = 3;
    localparam int SY_LOCK = 4;
    localparam int SY_DBG  = 5;
    localparam int SY_FAIL = 6;
    localparam int SY_OSC  = 7;
    localparam int SY_PLL  = 8;

    logic [8:0]      syncIn;
    logic [8:0]      syncLvl;
    logic            pinAsserted;
    logic [4:0]      prev_reg;
    logic [4:0]      prev_next;
    logic [8:0]      ev;
    logic            porPend_reg;
    srm_state_type   state_reg;
    srm_state_type   state_next;
    logic [4:0]      cnt_reg;
    logic [4:0]      cnt_next;
    logic            coreOnly_reg;
    logic            coreOnly_next;
    logic [31:0]     cause_reg;
    logic [31:0]     cause_next;
    logic [31:0]     mask_reg;
    logic [31:0]     mask_next;
    srm_fields_type  fld_reg;
    srm_fields_type  fld_next;
    logic            held;
    logic            wrCause;
    logic            wrBlk;
    logic            wrAirc;

    assign syncIn = {pllStable, oscStable, clockFail, debugMode, lockup,
                     brownout, lowVoltage, wdogTimeout, ~extResetPin_n};

    srm_sync #(.W(9)) u_sync (
        .clk  (clk),
        .rst  (rst),
        .din  (syncIn),
        .dout (syncLvl)
    );

    srm_pin_filter #(.CYC(PIN_FILTER_CYCLES)) u_pin (
        .clk      (clk),
        .rst      (rst),
        .pinLow   (syncLvl[SY_PIN]),
        .asserted (pinAsserted)
    );

    assign wrCause = regWr && regAddr == OFS_CAUSE;
    assign wrBlk   = regWr && regAddr == OFS_BLKRST;
    assign wrAirc  = regWr && regAddr == OFS_AIRC;

    // Event detection: rising edges of hardware sources, soft writes
    always_comb begin
        prev_next = {syncLvl[SY_LOCK], syncLvl[SY_BO], syncLvl[SY_LV],
                     syncLvl[SY_WDT], pinAsserted};
        ev = 9'h0;
        ev[SRC_POR]  = porPend_reg;
        ev[SRC_PIN]  = pinAsserted && !prev_reg[0];
        ev[SRC_WDT]  = syncLvl[SY_WDT] && !prev_reg[1];
        ev[SRC_LV]   = syncLvl[SY_LV] && !prev_reg[2];
        ev[SRC_BO]   = syncLvl[SY_BO] && !prev_reg[3];
        // Lockup is ignored while a debugger holds the core
        ev[SRC_LOCK] = syncLvl[SY_LOCK] && !prev_reg[4]
                       && !syncLvl[SY_DBG];
        ev[SRC_CHIP] = wrBlk && regWdata[BLK_CHIP_BIT];
        ev[SRC_MCU]  = wrAirc && regWdata[AIRC_MCU_BIT];
        ev[SRC_CORE] = wrBlk && regWdata[BLK_CORE_BIT];
    end

    // Reset stretch; level sources hold the reset while they last
    always_comb begin
        held          = pinAsserted || syncLvl[SY_LV] || syncLvl[SY_BO];
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        coreOnly_next = coreOnly_reg;
        case (state_reg)
            ST_IDLE: begin
                coreOnly_next = 1'b0;
            end
            ST_HOLD: begin
                if (cnt_reg != 5'h0) begin
                    cnt_next = cnt_reg - 5'h1;
                end else if (!held) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_HOLD;
            end
        endcase
        if (ev != 9'h0) begin
            state_next = ST_HOLD;
            cnt_next   = 5'(STRETCH_CYC);
            // Core-only while nothing wider joins
            coreOnly_next = (ev == GRP_CORE)
                && (state_reg == ST_IDLE || coreOnly_reg);
        end
    end

    assign coreReset   = state_reg == ST_HOLD;
    assign periphReset = state_reg == ST_HOLD && !coreOnly_reg;

    // Cause flags and interrupt mask
    always_comb begin
        cause_next = cause_reg;
        mask_next  = mask_reg;
        if (wrCause) begin
            cause_next = cause_reg & ~regWdata;
        end
        if (regWr && regAddr == OFS_IMASK) begin
            mask_next = regWdata & CAUSE_MASK;
        end
        if ((ev & GRP_PERI) != 9'h0) begin
            mask_next = 32'h0;
        end
        // Every event present sets its flag; set beats clear
        for (int s = 0; s < NSRC; s++) begin
            if (ev[s]) begin
                cause_next[SRC_CAUSE[s]] = 1'b1;
            end
        end
    end

    assign irq = |(cause_reg & mask_reg);

    // Retained fields: software writes, then per-source reload
    always_comb begin
        fld_next = fld_reg;
        if (regWr) begin
            case (regAddr)
                OFS_WDCTL:  fld_next.wdogCtrl    = regWdata;
                OFS_WDALT:  fld_next.wdogAltCtrl = regWdata;
                OFS_WWCTL:  fld_next.wwdogCtrl   = regWdata;
                OFS_WWCNT:  fld_next.wwdogCount  = regWdata[5:0];
                OFS_WWRLD:  fld_next.wwdogReload = regWdata;
                OFS_WWSTS:  fld_next.wwdogFlags  = regWdata;
                OFS_BOOT: begin
                    fld_next.bootSelect = regWdata[BOOT_BS_BIT];
                    fld_next.bootLock   = regWdata[BOOT_BL_BIT];
                end
                OFS_BODCTL: begin
                    fld_next.bodEnable      = regWdata[BOD_EN_BIT];
                    fld_next.bodLevel       =
                        regWdata[BOD_LVL_LSB +: 2];
                    fld_next.bodResetEnable = regWdata[BOD_RST_BIT];
                end
                OFS_CLKCTL: begin
                    fld_next.wdogClockSelect =
                        regWdata[CLK_WSEL_LSB +: 2];
                    fld_next.wdogClockGate   = regWdata[CLK_WGATE_BIT];
                    fld_next.lowSpeedXtalEnable =
                        regWdata[CLK_LXT_BIT];
                end
                default: begin
                end
            endcase
        end
        if ((ev & GRP_FULL) != 9'h0) begin
            fld_next.wdogCtrl = WDCTL_RST;
            fld_next.wdogCtrl[WD_RSTEN_BIT] = userCfg0[CF0_RSTEN_BIT];
            fld_next.wdogCtrl[WD_EN_BIT]    = userCfg0[CF0_WDEN_BIT];
            fld_next.wdogAltCtrl   = 32'h0;
            fld_next.wwdogCtrl     = WWCTL_RST;
            fld_next.wwdogCount    = WWCNT_RST;
            fld_next.wwdogReload   = 32'h0;
            fld_next.wwdogFlags    = 32'h0;
            fld_next.bootSelect    = userCfg0[CF0_CBS_LSB + 1];
            fld_next.bootLock      = userCfg0[CF0_BL_BIT];
            fld_next.cfgBootSource = userCfg0[CF0_CBS_LSB +: 2];
            fld_next.dataFlashBase = userCfg1;
        end
        if ((ev & GRP_BOD) != 9'h0) begin
            fld_next.bodEnable      = userCfg0[CF0_BROWNOUT_ENABLE_BIT];
            fld_next.bodLevel       = userCfg0[CF0_BROWNOUT_LEVEL_LSB +: 2];
            fld_next.bodResetEnable = userCfg0[CF0_BODRST_BIT];
        end
        if ((ev & GRP_WSEL) != 9'h0) begin
            fld_next.wdogClockSelect = WSEL_RST;
            fld_next.clockFailFlag   = 1'b0;
        end
        if ((ev & GRP_WGATE) != 9'h0) begin
            fld_next.wdogClockGate = 1'b1;
        end
        if ((ev & GRP_POR) != 9'h0) begin
            fld_next.oscStableFlag      = 1'b0;
            fld_next.pllStableFlag      = 1'b0;
            fld_next.lowSpeedXtalEnable = 1'b0;
        end
        // Status set by clock hardware wins over a same-cycle clear
        if (syncLvl[SY_FAIL]) begin
            fld_next.clockFailFlag = 1'b1;
        end
        if (syncLvl[SY_OSC]) begin
            fld_next.oscStableFlag = 1'b1;
        end
        if (syncLvl[SY_PLL]) begin
            fld_next.pllStableFlag = 1'b1;
        end
    end

    assign fields = fld_reg;

    // Power-on: fields start at zero and are loaded from config
    // in the first clock after release, since async reset takes constants
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            porPend_reg  <= 1'b1;
            prev_reg     <= 5'h0;
            state_reg    <= ST_HOLD;
            cnt_reg      <= 5'(STRETCH_CYC);
            coreOnly_reg <= 1'b0;
            cause_reg    <= CAUSE_POR_VAL;
            mask_reg     <= 32'h0;
            fld_reg      <= '0;
        end else begin
            porPend_reg  <= 1'b0;
            prev_reg     <= prev_next;
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            coreOnly_reg <= coreOnly_next;
            cause_reg    <= cause_next;
            mask_reg     <= mask_next;
            fld_reg      <= fld_next;
        end
    end

    // Read data, valid in the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdata <= 32'h0;
        end else if (regRd) begin
            case (regAddr)
                OFS_CAUSE:  regRdata <= cause_reg;
                OFS_IMASK:  regRdata <= mask_reg;
                OFS_WDCTL:  regRdata <= fld_reg.wdogCtrl;
                OFS_WDALT:  regRdata <= fld_reg.wdogAltCtrl;
                OFS_WWCTL:  regRdata <= fld_reg.wwdogCtrl;
                OFS_WWCNT:  regRdata <= {26'h0, fld_reg.wwdogCount};
                OFS_WWRLD:  regRdata <= fld_reg.wwdogReload;
                OFS_WWSTS:  regRdata <= fld_reg.wwdogFlags;
                OFS_BOOT:   regRdata <= {15'h0, fld_reg.bootLock, 12'h0,
                                fld_reg.cfgBootSource, fld_reg.bootSelect,
                                1'b0};
                OFS_DFBASE: regRdata <= fld_reg.dataFlashBase;
                OFS_BODCTL: regRdata <= {28'h0, fld_reg.bodResetEnable,
                                fld_reg.bodLevel, fld_reg.bodEnable};
                OFS_CLKCTL: regRdata <= {23'h0,
                                fld_reg.lowSpeedXtalEnable, 3'h0,
                                fld_reg.wdogClockGate, 2'h0,
                                fld_reg.wdogClockSelect};
                OFS_CLKSTS: regRdata <= {24'h0, fld_reg.clockFailFlag,
                                4'h0, fld_reg.pllStableFlag, 1'b0,
                                fld_reg.oscStableFlag};
                // Request bits self-clear, unmapped reads give zero
                default:    regRdata <= 32'h0;
            endcase
        end else begin
            regRdata <= 32'h0;
        end
    end

    AST_POR_CAUSE: assert property (@(posedge clk) disable iff (rst)
        porPend_reg |=> cause_reg[0] && periphReset)
        else $error("power-on did not flag cause bit 0");
    AST_CHIP_RST: assert property (@(posedge clk) disable iff (rst)
        ev[SRC_CHIP] |=> cause_reg[0] && coreReset && periphReset)
        else $error("chip reset request not honoured");
    AST_CORE_ONLY: assert property (@(posedge clk) disable iff (rst)
        state_reg == ST_IDLE && ev == GRP_CORE
        |=> coreReset && !periphReset && cause_reg[7])
        else $error("core-only reset touched peripherals");
    AST_MCU_BOOT: assert property (@(posedge clk) disable iff (rst)
        ev == (9'h1 << SRC_MCU)
        |=> cause_reg[5] && periphReset && $stable(fld_reg.bootSelect))
        else $error("MCU reset lost cause or boot choice");
    // The release edge still samples reset-time state, hence the !rst
    AST_WDCTL_VAL: assert property (@(posedge clk) disable iff (rst)
        !rst && (ev & GRP_FULL) != 9'h0 |=> fld_reg.wdogCtrl ==
        (WDCTL_RST | {24'h0, $past(userCfg0[CF0_WDEN_BIT]), 5'h0,
                      $past(userCfg0[CF0_RSTEN_BIT]), 1'b0}))
        else $error("watchdog control not reloaded");
    AST_WWDOG: assert property (@(posedge clk) disable iff (rst)
        !rst && (ev & GRP_FULL) != 9'h0 |=> fld_reg.wwdogCtrl == WWCTL_RST
        && fld_reg.wwdogCount == WWCNT_RST)
        else $error("window watchdog not reset");
    AST_BOD_KEEP: assert property (@(posedge clk) disable iff (rst)
        ev == (9'h1 << SRC_BO) && !regWr |=> $stable(fld_reg.bodLevel)
        && $stable(fld_reg.bodEnable) && $stable(fld_reg.bodResetEnable))
        else $error("brown-out fields changed on brown-out reset");
    AST_W1C: assert property (@(posedge clk) disable iff (rst)
        wrCause && ev == 9'h0 |=> cause_reg == $past(cause_reg & ~regWdata))
        else $error("cause flags not cleared by writing one");
    AST_MULTI: assert property (@(posedge clk) disable iff (rst)
        ev[SRC_LOCK] && ev[SRC_LV] |=> cause_reg[8] && cause_reg[3])
        else $error("simultaneous events lost a flag");
    AST_HOLD: assert property (@(posedge clk) disable iff (rst)
        $rose(pinAsserted) |=> periphReset [*4])
        else $error("pin reset not held");
endmodule : srm_reset_manager
`default_nettype wire

// ===== srm_reset_manager_tb.sv
// Self-checking bench for the reset source manager
`timescale 1ns/1ns
`default_nettype none
module srm_reset_manager_tb;
    import srm_pkg::*;
    logic clk, rst, regWr, regRd, pinN, wdog, lowV, bo, lock, dbg, cf, osc;
    logic [7:0]  regAddr;
    logic [31:0] regWdata, regRdata, cfg0, cfg1, d;
    logic coreRst, perRst, irq, sawPer;
    srm_fields_type f;
    int failures, comparisons, ticks;
    // Short filter keeps the pin scenario brief
    srm_reset_manager #(.PIN_FILTER_CYCLES(20)) dut (.clk, .rst, .regAddr,
        .regWdata, .regWr, .regRd, .regRdata, .extResetPin_n(pinN),
        .wdogTimeout(wdog), .lowVoltage(lowV), .brownout(bo),
        .lockup(lock), .debugMode(dbg), .clockFail(cf), .oscStable(osc),
        .pllStable(osc), .userCfg0(cfg0), .userCfg1(cfg1),
        .coreReset(coreRst), .periphReset(perRst), .irq, .fields(f));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        ticks <= ticks + 1;
        if (ticks == 8000) begin
            failures++;
            give_verdict();
        end
    end
    task chk(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask : chk
    task give_verdict;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    task wr(input logic [7:0] a, input logic [31:0] v);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task cause(input logic [31:0] e);
        regAddr <= 8'h00;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 chk("cause", regRdata, e);
        @(posedge clk);
        wr(8'h00, e);
    endtask : cause
    // Events take a few edges to show, so give them time before polling
    task idle;
        int n;
        n = 0;
        sawPer = perRst;
        repeat (4) begin
            @(posedge clk);
            sawPer |= perRst;
        end
        while (coreRst !== 1'b0 && n < 400) begin
            sawPer |= perRst;
            @(posedge clk);
            n++;
        end
        // A reset that never ends counts as a mismatch
        if (coreRst !== 1'b0) failures++;
    endtask : idle
    function automatic logic [31:0] wdx(input logic [31:0] c);
        wdx = WDCTL_RST | {24'h0, c[31], 5'h0, c[30], 1'b0};
    endfunction : wdx
    initial begin
        {rst, pinN} = 2'h3;
        {regWr, regRd, wdog, lowV, bo, lock, dbg, cf, osc} = 9'h000;
        {regAddr, regWdata} = 40'h0;
        cfg0 = 32'h40b0_0082;
        cfg1 = 32'h0001_f000;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        idle();
        cause(32'h1);
        chk("wdctl", f.wdogCtrl, wdx(cfg0));
        chk("wwctl", f.wwdogCtrl, WWCTL_RST);
        chk("dfbase", f.dataFlashBase, cfg1);
        chk("wsel", f.wdogClockSelect, 32'h3);
        cfg0 <= 32'h8040_0000;
        wr(8'h04, 32'h2);
        idle();
        cause(32'h80);
        chk("core per", sawPer, 32'h0);
        chk("core wd", f.wdogCtrl, 32'h0702);
        chk("core bodlvl", f.bodLevel, 32'h1);
        bo <= 1'b1;
        repeat (8) @(posedge clk);
        bo <= 1'b0;
        idle();
        cause(32'h10);
        chk("bo per", sawPer, 32'h1);
        chk("bo bodlvl", f.bodLevel, 32'h1);
        chk("bo wd", f.wdogCtrl, 32'h0780);
        cfg0 <= 32'h40b0_0082;
        wr(8'h30, 32'h0);
        wr(8'h08, 32'h4);
        idle();
        cause(32'h20);
        chk("mcu bs", f.bootSelect, 32'h0);
        chk("mcu bod", f.bodLevel, 32'h1);
        wr(8'h34, 32'h0);
        cf <= 1'b1;
        wdog <= 1'b1;
        repeat (2) @(posedge clk);
        {cf, wdog} <= 2'h0;
        idle();
        cause(32'h4);
        chk("wd gate", f.wdogClockGate, 32'h1);
        chk("wd sel", f.wdogClockSelect, 32'h0);
        chk("wd fail", f.clockFailFlag, 32'h1);
        // Debugger present: the lockup pulse must not reset either
        {pinN, dbg, lock} <= 3'h3;
        repeat (10) @(posedge clk);
        {pinN, lock} <= 2'h2;
        repeat (30) @(posedge clk);
        chk("glitch", coreRst, 32'h0);
        cause(32'h0);
        {pinN, dbg} <= 2'h0;
        repeat (40) @(posedge clk);
        pinN <= 1'b1;
        idle();
        cause(32'h2);
        chk("pin sel", f.wdogClockSelect, 32'h3);
        chk("pin fail", f.clockFailFlag, 32'h0);
        {lock, lowV, osc} <= 3'h7;
        repeat (8) @(posedge clk);
        {lock, lowV, osc} <= 3'h0;
        idle();
        cause(32'h108);
        wr(8'h34, 32'h100);
        wr(8'h04, 32'h1);
        idle();
        cause(32'h1);
        chk("chip per", sawPer, 32'h1);
        chk("chip lxt", f.lowSpeedXtalEnable, 32'h1);
        chk("chip osc", {f.pllStableFlag, f.oscStableFlag}, 32'h3);
        wr(8'h0c, 32'h80);
        wr(8'h04, 32'h2);
        idle();
        chk("irq set", irq, 32'h1);
        cause(32'h80);
        chk("irq clr", irq, 32'h0);
        // Power-on in mid-run clears what no other source touches
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        idle();
        chk("por lxt", f.lowSpeedXtalEnable, 32'h0);
        chk("por osc", {f.pllStableFlag, f.oscStableFlag}, 32'h0);
        cause(32'h1);
        give_verdict();
    end
endmodule : srm_reset_manager_tb
`default_nettype wire
